/* File: rtl/cca_pkg.sv */
// Constants, register map and mode encodings of the capture/compare array.
// Assumes one 50 MHz clock and an AHB-Lite master with 32-bit data.
package cca_pkg;
  // Two time bases, each a pair of timers
  localparam int unsigned NUM_BASES = 2;
  localparam int unsigned NUM_TMR = 2 * NUM_BASES;

  // Register map, byte addresses inside the slave window
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_TMR_CTL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_TMR_RLD = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_TMR_VAL = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h030;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 12'h034;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 12'h038;
  localparam logic [ADDR_W-1:0] OFS_CC_VAL = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_CC_CTL = 12'h200;
  localparam int unsigned WORD_BYTES = 4;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Timer control fields
  localparam int unsigned TC_PRE_LSB = 0;
  localparam int unsigned TC_PRE_W = 3;
  localparam int unsigned TC_SRC_GPT = 3;
  localparam int unsigned TC_SRC_EXT = 4;
  localparam int unsigned TC_RUN = 5;
  localparam int unsigned TC_W = 6;

  // Channel control fields
  localparam int unsigned CC_MODE_LSB = 0;
  localparam int unsigned CC_MODE_W = 3;
  localparam int unsigned CC_ALLOC = 3;
  localparam int unsigned CC_EDGE_LSB = 4;
  localparam int unsigned CC_EDGE_W = 2;
  localparam int unsigned CC_W = 6;
  localparam int unsigned EDGE_RISE_BIT = 0;
  localparam int unsigned EDGE_FALL_BIT = 1;

  // Timing: two system time units per clock, finest count step 16 units
  localparam int unsigned STU_PER_CLK = 2;
  localparam int unsigned MIN_RES_STU = 16;
  localparam int unsigned MIN_DIV_CYC = MIN_RES_STU / STU_PER_CLK;
  localparam int unsigned PRE_W = $clog2(MIN_DIV_CYC) + (1 << TC_PRE_W);

  // Channels whose pins can only capture
  localparam int unsigned NO_OUT_FIRST = 24;
  localparam int unsigned NO_OUT_LAST = 27;

  typedef enum logic [2:0] {
    MODE_OFF, MODE_CAPTURE, MODE_CMP0, MODE_CMP1, MODE_CMP2, MODE_CMP3, MODE_DOUBLE
  } cca_mode_e;
endpackage

/* File: rtl/cca_capture_compare_array.sv */
// Capture/compare array: two time bases of two reloadable timers, each base
// serving its own bank of dual-purpose capture/compare channels.
// Assumes an AHB-Lite master on clk, asynchronous pins on cc_pin_i and
// count_pin_i, and a same-clock one-cycle overflow pulse from timer six.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
module cca_capture_compare_array
  import cca_pkg::*;
#(
  parameter int unsigned TMR_W = 16,
  parameter int unsigned CH_PER_BASE = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_BASES-1:0] count_pin_i,
  input wire logic general_purpose_timer_six_ovf_i,
  input wire logic [NUM_BASES*CH_PER_BASE-1:0] cc_pin_i,
  output logic [NUM_BASES*CH_PER_BASE-1:0] cc_pin_o,
  output logic [NUM_BASES*CH_PER_BASE-1:0] cc_pin_oe_n,
  output logic irq_o
);
  localparam int unsigned NUM_CH = NUM_BASES * CH_PER_BASE;
  localparam int unsigned HALF = CH_PER_BASE / 2;
  localparam logic [TMR_W-1:0] TMAX = {TMR_W{1'b1}};

  // Status, clear and enable are one word each, so the array must fit 32 bits
  if (TMR_W < 2 || TMR_W > 32 || CH_PER_BASE < 2 || (CH_PER_BASE % 2) != 0 ||
      NUM_CH > 32) begin : g_bad_params
    $error("cca: unsupported TMR_W or CH_PER_BASE");
  end

  logic [TMR_W-1:0] tmr_q [NUM_TMR];
  logic [TMR_W-1:0] rld_q [NUM_TMR];
  logic [TC_W-1:0] tctl_q [NUM_TMR];
  logic [NUM_TMR-1:0] step_d, step_q, ovf_q;
  logic [PRE_W-1:0] pre_q;
  logic [TMR_W-1:0] cc_val_q [NUM_CH];
  logic [CC_W-1:0] cc_ctl_q [NUM_CH];
  logic [NUM_CH-1:0] done_q, pin_out_q, pin_oe_n_q, stat_q, en_q;
  logic [NUM_CH-1:0] pin_m_q, pin_s_q, pin_p_q;
  logic [NUM_BASES-1:0] cnt_m_q, cnt_s_q, cnt_p_q, cnt_rise;
  logic irq_q, hreadyout_q, hresp_q, rd_pend_q, wr_pend_q;
  logic [31:0] hrdata_q, rd_data;
  logic [ADDR_W-1:0] acc_addr_q;
  logic addr_ph;
  logic [NUM_TMR-1:0] w_tctl, w_trld, w_tval;
  logic [NUM_CH-1:0] w_ccval, w_ccctl;
  logic w_clr, w_en;
  logic [1:0] ch_tmr [NUM_CH];
  cca_mode_e ch_mode [NUM_CH];
  logic [NUM_CH-1:0] match, cap, evt, toggle, set3, clr3, done_set, drive;

  // Outputs straight from flops
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign cc_pin_o = pin_out_q;
  assign cc_pin_oe_n = pin_oe_n_q;
  assign irq_o = irq_q;

  // Prescaler tick for a select: one pulse every MIN_DIV_CYC << sel cycles
  function automatic logic pre_tick(input logic [PRE_W-1:0] cnt,
                                    input logic [TC_PRE_W-1:0] sel);
    logic [PRE_W-1:0] mask;
    mask = (PRE_W'(MIN_DIV_CYC) << sel) - PRE_W'(1);
    return (cnt & mask) == mask;
  endfunction

  // ---------------- AHB-Lite slave ----------------
  assign addr_ph = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;

  // Writes finish with no wait; reads take one wait state so that a read
  // right after a write sees the written value
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hreadyout_q <= 1'b1;
      hresp_q <= HRESP_OKAY;
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      acc_addr_q <= '0;
      hrdata_q <= '0;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_data;
      hreadyout_q <= 1'b1;
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_ph && hwrite;
      rd_pend_q <= addr_ph && !hwrite;
      if (addr_ph) begin
        acc_addr_q <= haddr[ADDR_W-1:0];
      end
      if (addr_ph && !hwrite) begin
        hreadyout_q <= 1'b0;
      end
    end
  end

  // Write strobes, valid in the data phase of a write
  always_comb begin
    for (int t = 0; t < NUM_TMR; t++) begin
      w_tctl[t] = wr_pend_q && acc_addr_q == OFS_TMR_CTL + ADDR_W'(WORD_BYTES * t);
      w_trld[t] = wr_pend_q && acc_addr_q == OFS_TMR_RLD + ADDR_W'(WORD_BYTES * t);
      w_tval[t] = wr_pend_q && acc_addr_q == OFS_TMR_VAL + ADDR_W'(WORD_BYTES * t);
    end
    for (int c = 0; c < NUM_CH; c++) begin
      w_ccval[c] = wr_pend_q && acc_addr_q == OFS_CC_VAL + ADDR_W'(WORD_BYTES * c);
      w_ccctl[c] = wr_pend_q && acc_addr_q == OFS_CC_CTL + ADDR_W'(WORD_BYTES * c);
    end
    w_clr = wr_pend_q && acc_addr_q == OFS_IRQ_CLR;
    w_en = wr_pend_q && acc_addr_q == OFS_IRQ_EN;
  end

  // Read mux; unmapped and write-only words read as zero
  always_comb begin
    rd_data = '0;
    for (int t = 0; t < NUM_TMR; t++) begin
      if (acc_addr_q == OFS_TMR_CTL + ADDR_W'(WORD_BYTES * t)) rd_data = 32'(tctl_q[t]);
      if (acc_addr_q == OFS_TMR_RLD + ADDR_W'(WORD_BYTES * t)) rd_data = 32'(rld_q[t]);
      if (acc_addr_q == OFS_TMR_VAL + ADDR_W'(WORD_BYTES * t)) rd_data = 32'(tmr_q[t]);
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (acc_addr_q == OFS_CC_VAL + ADDR_W'(WORD_BYTES * c)) rd_data = 32'(cc_val_q[c]);
      if (acc_addr_q == OFS_CC_CTL + ADDR_W'(WORD_BYTES * c)) rd_data = 32'(cc_ctl_q[c]);
    end
    if (acc_addr_q == OFS_IRQ_STAT) rd_data = 32'(stat_q);
    if (acc_addr_q == OFS_IRQ_EN) rd_data = 32'(en_q);
  end

  // ---------------- Pin synchronisers ----------------
  // Third stage only remembers the previous settled level for edge detection
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      pin_p_q <= '0;
      cnt_m_q <= '0;
      cnt_s_q <= '0;
      cnt_p_q <= '0;
    end else begin
      pin_m_q <= cc_pin_i;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
      cnt_m_q <= count_pin_i;
      cnt_s_q <= cnt_m_q;
      cnt_p_q <= cnt_s_q;
    end
  end
  assign cnt_rise = cnt_s_q & ~cnt_p_q;

  // ---------------- Time bases ----------------
  // Free-running prescaler shared by all four timers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  // Count enable of each timer; external count only on the first of a pair
  always_comb begin
    for (int t = 0; t < NUM_TMR; t++) begin
      if (!tctl_q[t][TC_RUN]) begin
        step_d[t] = 1'b0;
      end else if (tctl_q[t][TC_SRC_EXT] && (t % 2) == 0) begin
        step_d[t] = cnt_rise[t / 2];
      end else if (tctl_q[t][TC_SRC_GPT]) begin
        step_d[t] = general_purpose_timer_six_ovf_i;
      end else begin
        step_d[t] = pre_tick(pre_q, tctl_q[t][TC_PRE_LSB +: TC_PRE_W]);
      end
    end
  end

  // Up-counting timers that reload on overflow; a software load wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int t = 0; t < NUM_TMR; t++) begin
        tmr_q[t] <= '0;
        rld_q[t] <= '0;
        tctl_q[t] <= '0;
      end
      step_q <= '0;
      ovf_q <= '0;
    end else begin
      for (int t = 0; t < NUM_TMR; t++) begin
        if (w_tctl[t]) tctl_q[t] <= hwdata[TC_W-1:0];
        if (w_trld[t]) rld_q[t] <= hwdata[TMR_W-1:0];
        if (w_tval[t]) begin
          tmr_q[t] <= hwdata[TMR_W-1:0];
        end else if (step_d[t]) begin
          tmr_q[t] <= (tmr_q[t] == TMAX) ? rld_q[t] : TMR_W'(tmr_q[t] + 1'b1);
        end
        step_q[t] <= step_d[t] && !w_tval[t];
        ovf_q[t] <= step_d[t] && !w_tval[t] && tmr_q[t] == TMAX;
      end
    end
  end

  // ---------------- Channels ----------------
  // Compare is judged the cycle after each count step, against the new value
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ch_tmr[c] = 2'((c / CH_PER_BASE) * 2) | {1'b0, cc_ctl_q[c][CC_ALLOC]};
      ch_mode[c] = cca_mode_e'(cc_ctl_q[c][CC_MODE_LSB +: CC_MODE_W]);
      match[c] = step_q[ch_tmr[c]] && tmr_q[ch_tmr[c]] == cc_val_q[c];
      cap[c] = ch_mode[c] == MODE_CAPTURE &&
               ((cc_ctl_q[c][CC_EDGE_LSB + EDGE_RISE_BIT] && pin_s_q[c] && !pin_p_q[c]) ||
                (cc_ctl_q[c][CC_EDGE_LSB + EDGE_FALL_BIT] && !pin_s_q[c] && pin_p_q[c]));
    end
    for (int c = 0; c < NUM_CH; c++) begin
      toggle[c] = 1'b0;
      set3[c] = 1'b0;
      clr3[c] = 1'b0;
      done_set[c] = 1'b0;
      drive[c] = 1'b0;
      unique case (ch_mode[c])
        MODE_OFF: evt[c] = 1'b0;
        MODE_CAPTURE: evt[c] = cap[c];
        MODE_CMP0: evt[c] = match[c];
        MODE_CMP1: begin
          evt[c] = match[c];
          toggle[c] = match[c];
          drive[c] = 1'b1;
        end
        MODE_CMP2: begin
          evt[c] = match[c] && (!done_q[c] || ovf_q[ch_tmr[c]]);
          done_set[c] = evt[c];
        end
        MODE_CMP3: begin
          evt[c] = match[c] && (!done_q[c] || ovf_q[ch_tmr[c]]);
          done_set[c] = evt[c];
          set3[c] = evt[c];
          clr3[c] = ovf_q[ch_tmr[c]];
          drive[c] = 1'b1;
        end
        MODE_DOUBLE: begin
          evt[c] = match[c];
          // Lower channel of a pair owns the pin; upper one only adds matches
          if ((c % CH_PER_BASE) < HALF) begin
            toggle[c] = match[c] ||
                        (match[c + HALF] && ch_mode[c + HALF] == MODE_DOUBLE);
            drive[c] = 1'b1;
          end
        end
        default: evt[c] = 1'b0;
      endcase
      if (c >= NO_OUT_FIRST && c <= NO_OUT_LAST) begin
        toggle[c] = 1'b0;
        set3[c] = 1'b0;
        drive[c] = 1'b0;
      end
    end
  end

  // Channel registers: capture beats a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cc_val_q[c] <= '0;
        cc_ctl_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (cap[c]) begin
          cc_val_q[c] <= tmr_q[ch_tmr[c]];
        end else if (w_ccval[c]) begin
          cc_val_q[c] <= hwdata[TMR_W-1:0];
        end
        if (w_ccctl[c]) cc_ctl_q[c] <= hwdata[CC_W-1:0];
      end
    end
  end

  // Once-per-period lock; a match in the overflow cycle belongs to the new period
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_q <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (done_set[c]) begin
          done_q[c] <= 1'b1;
        end else if (ovf_q[ch_tmr[c]]) begin
          done_q[c] <= 1'b0;
        end
      end
    end
  end

  // Pin drivers; set on match wins over the overflow reset in mode 3
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (toggle[c]) begin
          pin_out_q[c] <= !pin_out_q[c];
        end else if (set3[c]) begin
          pin_out_q[c] <= 1'b1;
        end else if (clr3[c]) begin
          pin_out_q[c] <= 1'b0;
        end
      end
      pin_oe_n_q <= ~drive;
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stat_q <= '0;
      en_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~(w_clr ? hwdata[NUM_CH-1:0] : '0)) | evt;
      if (w_en) en_q <= hwdata[NUM_CH-1:0];
      irq_q <= |(stat_q & en_q);
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_no_out; &pin_oe_n_q[NO_OUT_LAST:NO_OUT_FIRST]; endproperty
  a_no_out: assert property (p_no_out) else $error("input-only pin driven");
  // Per-channel checks, so whichever channels a test uses are watched
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
    wire [TMR_W-1:0] cap_src = tmr_q[ch_tmr[c]];
    property p_capture; cap[c] |=> cc_val_q[c] == $past(cap_src); endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong");
    property p_cap_irq; cap[c] |=> stat_q[c]; endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing");
    property p_m0; ch_mode[c] == MODE_CMP0 && match[c] |=> stat_q[c]; endproperty
    a_m0: assert property (p_m0) else $error("mode 0 irq missing");
    property p_m1;
      ch_mode[c] == MODE_CMP1 && match[c] && (c < NO_OUT_FIRST || c > NO_OUT_LAST)
        |=> pin_out_q[c] != $past(pin_out_q[c]);
    endproperty
    a_m1: assert property (p_m1) else $error("mode 1 no toggle");
    property p_m2;
      ch_mode[c] == MODE_CMP2 && done_q[c] && !ovf_q[ch_tmr[c]] |-> !evt[c];
    endproperty
    a_m2: assert property (p_m2) else $error("mode 2 second irq");
    property p_m3;
      ch_mode[c] == MODE_CMP3 && ovf_q[ch_tmr[c]] && !match[c] |=> !pin_out_q[c];
    endproperty
    a_m3: assert property (p_m3) else $error("mode 3 pin not reset");
    if ((c % CH_PER_BASE) < HALF) begin : g_dbl
      property p_dbl;
        ch_mode[c] == MODE_DOUBLE && ch_mode[c + HALF] == MODE_DOUBLE && match[c + HALF] &&
          !match[c] |=> pin_out_q[c] != $past(pin_out_q[c]) && !pin_oe_n_q[c];
      endproperty
      a_dbl: assert property (p_dbl) else $error("double mode no toggle");
    end
  end
  property p_step;
    step_d[0] && !w_tval[0] && tmr_q[0] != TMAX |=> tmr_q[0] == TMR_W'($past(tmr_q[0]) + 1'b1);
  endproperty
  a_step: assert property (p_step) else $error("timer did not count");
  property p_ext;
    tctl_q[0][TC_RUN] && tctl_q[0][TC_SRC_EXT] && cnt_rise[0] && !w_tval[0] |=> step_q[0];
  endproperty
  a_ext: assert property (p_ext) else $error("external count lost");
  property p_init; $rose(reset_n) |-> cc_ctl_q[0] == '0 && pin_oe_n_q[0]; endproperty
  a_init: assert property (disable iff (1'b0) p_init) else $error("not disabled at reset");

  c_capture: cover property ((|cap) ##1 (|stat_q));
  c_m3: cover property ((|set3) ##[1:1000] (|clr3));
  c_dbl: cover property (ch_mode[0] == MODE_DOUBLE && toggle[0]);
  c_irq: cover property ($rose(irq_q));
endmodule

/* File: verification/cca_pin_model.sv */
// Far-side model: event sources on the channel and count pins, plus the
// overflow pulses of general purpose timer six.
// Assumes the device drives a channel pin only while its output enable is low.
`timescale 1ns/10ps
module cca_pin_model
  import cca_pkg::*;
(
  input wire logic clk,
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe_n,
  output logic [31:0] pin_i,
  output logic [NUM_BASES-1:0] cnt_o,
  output logic ovf_o
);
  logic [31:0] src_q;

  // Resolved wire level: a driving channel wins over the outside source
  assign pin_i = (pin_oe_n & src_q) | (~pin_oe_n & pin_o);

  // Quiet sources at time zero
  initial begin
    src_q = 32'h00000000;
    cnt_o = '0;
    ovf_o = 1'b0;
  end

  // Sources change just after an edge, as an outside event would
  task automatic set_pin(input int c, input logic v);
    @(posedge clk);
    src_q[c] <= v;
  endtask

  // One-cycle pulse, so each call is exactly one count step
  task automatic pulse_ovf();
    @(posedge clk);
    ovf_o <= 1'b1;
    @(posedge clk);
    ovf_o <= 1'b0;
  endtask

  // Wide pulse, so the input synchroniser cannot miss it
  task automatic count(input int b);
    @(posedge clk);
    cnt_o[b] <= 1'b1;
    repeat (3) @(posedge clk);
    cnt_o[b] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* File: verification/test_capture_compare_array.sv */
// Self-checking bench of the capture/compare array over its register bus.
// Assumes one 50 MHz clock and the pin model on the far side.
`timescale 1ns/10ps
module test_capture_compare_array
  import cca_pkg::*;
;
  localparam logic [31:0] CTL_GPT = 32'((1 << TC_SRC_GPT) | (1 << TC_RUN));
  localparam logic [31:0] CTL_EXT = 32'((1 << TC_SRC_EXT) | (1 << TC_RUN));
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp, irq_o, ovf;
  logic [31:0] haddr, hwdata, hrdata, q, cc_pin_i, cc_pin_o, cc_pin_oe_n;
  logic [1:0] htrans, count_pin_i;
  logic [2:0] hsize;
  int err_count, comparisons;
  int ch[6] = '{5, 6, 7, 8, 1, 9};
  cca_mode_e md[6] = '{MODE_CMP1, MODE_CMP0, MODE_CMP2, MODE_CMP3, MODE_DOUBLE, MODE_DOUBLE};

  cca_capture_compare_array i_cca_capture_compare_array (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .count_pin_i(count_pin_i), .general_purpose_timer_six_ovf_i(ovf),
    .cc_pin_i(cc_pin_i), .cc_pin_o(cc_pin_o), .cc_pin_oe_n(cc_pin_oe_n), .irq_o(irq_o)
  );

  cca_pin_model i_cca_pin_model (
    .clk(clk), .pin_o(cc_pin_o), .pin_oe_n(cc_pin_oe_n), .pin_i(cc_pin_i),
    .cnt_o(count_pin_i), .ovf_o(ovf)
  );

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      close_out();
    end
  endtask

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF);
    bus(1'b0, a, 32'h00000000);
    chk(q & m, e);
  endtask

  function automatic logic [11:0] at(input logic [11:0] b, input int i);
    return b + 12'(i * WORD_BYTES);
  endfunction

  // One timer-six step, then time for the match to reach the pins
  task automatic tick();
    i_cca_pin_model.pulse_ovf();
    repeat (4) @(posedge clk);
  endtask

  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h00000000;
    err_count = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    // Reset state, timer width and an unmapped place
    chk(cc_pin_oe_n, 32'hFFFFFFFF);
    chk({31'h0, irq_o}, 32'h00000000);
    rd(at(OFS_CC_CTL, 0), 32'h00000000);
    rd(OFS_IRQ_STAT, 32'h00000000);
    wr(at(OFS_TMR_RLD, 1), 32'h00012345);
    rd(at(OFS_TMR_RLD, 1), 32'h00002345);
    rd(12'h0FC, 32'h00000000);
    chk({31'h0, hresp}, 32'h00000000);
    $display("test reset done");
    // Capture on every edge choice; the timer is stopped so values are exact
    wr(OFS_IRQ_EN, 32'h00000008);
    for (int e = 1; e < 4; e++) begin
      wr(at(OFS_CC_CTL, 3), (32'(e) << CC_EDGE_LSB) | 32'(MODE_CAPTURE));
      wr(at(OFS_CC_VAL, 3), 32'h00000000);
      wr(at(OFS_TMR_VAL, 0), 32'h0000A000 + 32'(e));
      i_cca_pin_model.set_pin(3, 1'b1);
      repeat (8) @(posedge clk);
      chk({31'h0, irq_o}, 32'(e[0]));
      rd(at(OFS_CC_VAL, 3), e[0] ? 32'h0000A000 + 32'(e) : 32'h0);
      wr(OFS_IRQ_CLR, 32'h00000008);
      wr(at(OFS_TMR_VAL, 0), 32'h0000B000 + 32'(e));
      i_cca_pin_model.set_pin(3, 1'b0);
      repeat (8) @(posedge clk);
      chk({31'h0, irq_o}, 32'(e[1]));
      rd(at(OFS_CC_VAL, 3), e[1] ? 32'h0000B000 + 32'(e)
                          : (e[0] ? 32'h0000A000 + 32'(e) : 32'h0));
      rd(OFS_IRQ_STAT, 32'(e[1]) << 3);
    end
    // Status still set: masking must drop the interrupt line
    wr(OFS_IRQ_EN, 32'h00000000);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_o}, 32'h00000000);
    wr(OFS_IRQ_CLR, 32'h00000008);
    rd(OFS_IRQ_STAT, 32'h00000000);
    $display("test capture done");
    // Compare channels on timer 0, one per mode and a pair (1, 9) for double mode; channel 24 on base B
    wr(at(OFS_TMR_VAL, 0), 32'h00000010);
    wr(at(OFS_TMR_RLD, 0), 32'h00000010);
    for (int i = 0; i < 6; i++) begin
      wr(at(OFS_CC_VAL, ch[i]), ch[i] == 1 ? 32'h00000011 : 32'h00000012);
      wr(at(OFS_CC_CTL, ch[i]), 32'(md[i]));
    end
    wr(at(OFS_TMR_VAL, 2), 32'h00000011);
    wr(at(OFS_CC_VAL, 24), 32'h00000012);
    wr(at(OFS_CC_CTL, 24), 32'(MODE_CMP1));
    wr(at(OFS_TMR_CTL, 0), CTL_GPT);
    wr(at(OFS_TMR_CTL, 2), CTL_GPT);
    tick();
    chk({30'h0, cc_pin_oe_n[1], cc_pin_o[1]}, 32'h00000001);
    tick();
    chk({29'h0, cc_pin_o[8], cc_pin_o[5], cc_pin_o[1]}, 32'h00000006);
    chk({28'h0, cc_pin_oe_n[27:24]}, 32'h0000000F);
    rd(OFS_IRQ_STAT, 32'h000002C2, 32'h000002C2);
    // Rewind inside the same period: mode 2 stays quiet
    wr(OFS_IRQ_CLR, 32'hFFFFFFFF);
    wr(at(OFS_TMR_VAL, 0), 32'h00000010);
    tick();
    tick();
    rd(OFS_IRQ_STAT, 32'h00000040, 32'h000000C0);
    chk({30'h0, cc_pin_o[8], cc_pin_o[5]}, 32'h00000002);
    // Overflow clears the mode 3 pin and opens a new period
    wr(at(OFS_TMR_VAL, 0), 32'h0000FFFF);
    tick();
    chk({31'h0, cc_pin_o[8]}, 32'h00000000);
    wr(OFS_IRQ_CLR, 32'hFFFFFFFF);
    tick();
    tick();
    rd(OFS_IRQ_STAT, 32'h000000C0, 32'h000000C0);
    chk({31'h0, cc_pin_o[8]}, 32'h00000001);
    $display("test compare done");
    // External count inputs of both first timers
    for (int b = 0; b < 2; b++) begin
      wr(at(OFS_TMR_CTL, 2 * b), CTL_EXT);
      wr(at(OFS_TMR_VAL, 2 * b), 32'h00000100);
      repeat (3) i_cca_pin_model.count(b);
      wr(at(OFS_TMR_CTL, 2 * b), 32'h00000000);
      rd(at(OFS_TMR_VAL, 2 * b), 32'h00000103);
    end
    $display("test count done");
    // Prescaled count: a window of 8<<s clocks times four holds exactly four steps
    for (int s = 0; s < 2; s++) begin
      wr(at(OFS_TMR_VAL, 3), 32'h00000000);
      wr(at(OFS_TMR_CTL, 3), 32'(s) | 32'(1 << TC_RUN));
      repeat ((MIN_DIV_CYC << s) * 4 - 2) @(posedge clk);
      wr(at(OFS_TMR_CTL, 3), 32'h00000000);
      rd(at(OFS_TMR_VAL, 3), 32'h00000004);
    end
    $display("test prescale done");
    close_out();
  end
endmodule
